//--- eemu_regs.svh
// constants for the flash record store engine
`ifndef EEMU_REGS_SVH
`define EEMU_REGS_SVH
`define EEMU_PAGE_BYTES  7'd64
`define EEMU_LEN_MIN     4'd2
`define EEMU_LEN_MAX     4'd15
`define EEMU_BLANK       8'hFF
`define EEMU_FIFO_DEPTH  16
`define EEMU_DATA_W      8
`define EEMU_ERASE_NS    1000
`define EEMU_ERASE_CYC   ((`EEMU_ERASE_NS + 99) / 100)
`endif

//--- eemu_pkg.sv
// types for the flash record store engine
package eemu_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SCAN_REQ,
		ST_SCAN_WAIT,
		ST_ERASE,
		ST_ERASE_WAIT,
		ST_PROG,
		ST_MARK,
		ST_FETCH_REQ,
		ST_FETCH_WAIT,
		ST_DONE
	} state_e;
endpackage

//--- eemu_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module eemu_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;
	assign in_ready_o  = (cnt_q != (AW+1)'(D));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem[rd_q];
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_q] <= in_data_i;
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	fifo_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cnt_q <= (AW+1)'(D))
		else $error("fifo count over depth");
endmodule
`default_nettype wire

//--- eemu_core.sv
// flash record store engine: appends records to a 64 byte page
// Function
// - one 64 byte page is the erase unit and record area
// - store appends payload at next blank slot after last record
// - full page is erased then the new record is written at start
// - record is payload plus marker holding bytes still programmable
// - three byte payload gives sixteen records; fifteen gives four
// - fetch returns the payload of the most recent record
// - a detected length change abandons the request untouched
// - alignment and range are not checked; bad requests undefined
`timescale 1ns/1ps
`default_nettype none
`include "eemu_regs.svh"
module eemu_core (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// request: parameter block header
	input  wire logic       emulated_store_op_i,
	input  wire logic       emulated_fetch_op_i,
	input  wire logic [7:0] clock_rate_param_i,
	input  wire logic [3:0] payload_length_i,
	input  wire logic [7:0] page_addr_high_i,
	input  wire logic [7:0] page_addr_low_i,
	// payload stream in (store)
	input  wire logic       pay_valid_i,
	output logic            pay_ready_o,
	input  wire logic [7:0] pay_data_i,
	// payload stream out (fetch)
	output logic            rd_valid_o,
	input  wire logic       rd_ready_i,
	output logic [7:0]      rd_data_o,
	// flash array port
	output logic            fl_rd_o,
	output logic            fl_wr_o,
	output logic            fl_erase_o,
	output logic [15:0]     fl_addr_o,
	output logic [7:0]      fl_wdata_o,
	input  wire logic [7:0] fl_rdata_i,
	// status
	output logic            busy_o,
	output logic            done_o,
	output logic            abort_o,
	output logic [7:0]      erase_rate_o
);
	eemu_pkg::state_e st_q;
	logic [5:0]  off_q;
	logic [5:0]  last_q;
	logic        found_q;
	logic        store_q;
	logic [3:0]  len_q;
	logic [3:0]  prev_len_q;
	logic [3:0]  cnt_q;
	logic [15:0] base_q;
	logic [7:0]  wait_q;
	logic        fo_valid;
	logic [7:0]  fo_data;
	logic        fo_ready;
	logic        fi_ready;

	// record stride and marker value
	function automatic logic [6:0] stride(input logic [3:0] n);
		return {3'h0, n} + 7'd1;
	endfunction
	wire [6:0] next_off  = {1'b0, off_q} + stride(len_q);
	wire [6:0] room_left = `EEMU_PAGE_BYTES - next_off;
	// room for one more record behind the one just found
	wire       next_fits = (next_off + stride(len_q))
		<= `EEMU_PAGE_BYTES;
	wire       fits      = ({1'b0, off_q} + stride(len_q))
		<= `EEMU_PAGE_BYTES;
	wire [6:0] mark_pos  = {1'b0, off_q} + {3'h0, len_q};
	wire       mark_blank = (fl_rdata_i == `EEMU_BLANK);
	wire       len_bad   = (prev_len_q != 4'h0) &&
		(payload_length_i != prev_len_q);
	wire       start     = emulated_store_op_i || emulated_fetch_op_i;
	wire       in_take   = fo_valid && fo_ready;

	eemu_fifo #(.W(`EEMU_DATA_W), .D(`EEMU_FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (pay_valid_i),
		.in_ready_o  (fi_ready),
		.in_data_i   (pay_data_i),
		.out_valid_o (fo_valid),
		.out_ready_i (fo_ready),
		.out_data_o  (fo_data)
	);
	assign fo_ready = (st_q == eemu_pkg::ST_PROG) && (cnt_q != len_q);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q <= eemu_pkg::ST_IDLE;
			off_q <= '0;
			last_q <= '0;
			found_q <= 1'b0;
			store_q <= 1'b0;
			len_q <= '0;
			prev_len_q <= '0;
			cnt_q <= '0;
			base_q <= '0;
			wait_q <= '0;
			fl_rd_o <= 1'b0;
			fl_wr_o <= 1'b0;
			fl_erase_o <= 1'b0;
			fl_addr_o <= '0;
			fl_wdata_o <= '0;
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			abort_o <= 1'b0;
			erase_rate_o <= '0;
			pay_ready_o <= 1'b0;
		end else begin
			fl_rd_o <= 1'b0;
			fl_wr_o <= 1'b0;
			fl_erase_o <= 1'b0;
			done_o <= 1'b0;
			abort_o <= 1'b0;
			pay_ready_o <= fi_ready;
			case (st_q)
			eemu_pkg::ST_IDLE: begin
				if (start && len_bad) begin
					abort_o <= 1'b1;
				end else if (start) begin
					base_q <= {page_addr_high_i, page_addr_low_i};
					len_q <= payload_length_i;
					prev_len_q <= payload_length_i;
					store_q <= emulated_store_op_i;
					erase_rate_o <= clock_rate_param_i;
					off_q <= '0;
					found_q <= 1'b0;
					busy_o <= 1'b1;
					st_q <= eemu_pkg::ST_SCAN_REQ;
				end
			end
			eemu_pkg::ST_SCAN_REQ: begin
				if (!fits) begin
					cnt_q <= '0;
					st_q <= store_q ? eemu_pkg::ST_ERASE
						: eemu_pkg::ST_FETCH_REQ;
				end else begin
					fl_rd_o <= 1'b1;
					fl_addr_o <= base_q + {9'h0, mark_pos};
					st_q <= eemu_pkg::ST_SCAN_WAIT;
				end
			end
			eemu_pkg::ST_SCAN_WAIT: begin
				if (mark_blank) begin
					st_q <= store_q ? eemu_pkg::ST_PROG
						: eemu_pkg::ST_FETCH_REQ;
					cnt_q <= '0;
				end else begin
					last_q <= off_q;
					found_q <= 1'b1;
					// a 6-bit offset would wrap to 0 at 64 and scan forever
					if (next_fits) begin
						off_q <= next_off[5:0];
						st_q <= eemu_pkg::ST_SCAN_REQ;
					end else begin
						cnt_q <= '0;
						st_q <= store_q ? eemu_pkg::ST_ERASE
							: eemu_pkg::ST_FETCH_REQ;
					end
				end
			end
			eemu_pkg::ST_ERASE: begin
				fl_erase_o <= 1'b1;
				fl_addr_o <= base_q;
				wait_q <= 8'(`EEMU_ERASE_CYC);
				st_q <= eemu_pkg::ST_ERASE_WAIT;
			end
			eemu_pkg::ST_ERASE_WAIT: begin
				if (wait_q == 8'h00) begin
					off_q <= '0;
					cnt_q <= '0;
					st_q <= eemu_pkg::ST_PROG;
				end else begin
					wait_q <= wait_q - 8'h01;
				end
			end
			eemu_pkg::ST_PROG: begin
				if (cnt_q == len_q) begin
					st_q <= eemu_pkg::ST_MARK;
				end else if (in_take) begin
					fl_wr_o <= 1'b1;
					fl_addr_o <= base_q + {10'h0, off_q} + {12'h0, cnt_q};
					fl_wdata_o <= fo_data;
					cnt_q <= cnt_q + 4'h1;
				end
			end
			eemu_pkg::ST_MARK: begin
				fl_wr_o <= 1'b1;
				fl_addr_o <= base_q + {9'h0, mark_pos};
				fl_wdata_o <= {1'b0, room_left};
				st_q <= eemu_pkg::ST_DONE;
			end
			eemu_pkg::ST_FETCH_REQ: begin
				if (!found_q) begin
					st_q <= eemu_pkg::ST_DONE;
				end else if (!rd_valid_o || rd_ready_i) begin
					rd_valid_o <= 1'b0;
					if (cnt_q == len_q) begin
						st_q <= eemu_pkg::ST_DONE;
					end else begin
						fl_rd_o <= 1'b1;
						fl_addr_o <= base_q + {10'h0, last_q}
							+ {12'h0, cnt_q};
						st_q <= eemu_pkg::ST_FETCH_WAIT;
					end
				end
			end
			eemu_pkg::ST_FETCH_WAIT: begin
				rd_valid_o <= 1'b1;
				rd_data_o <= fl_rdata_i;
				cnt_q <= cnt_q + 4'h1;
				st_q <= eemu_pkg::ST_FETCH_REQ;
			end
			eemu_pkg::ST_DONE: begin
				if (!rd_valid_o || rd_ready_i) begin
					rd_valid_o <= 1'b0;
					done_o <= 1'b1;
					busy_o <= 1'b0;
					st_q <= eemu_pkg::ST_IDLE;
				end
			end
			default: st_q <= eemu_pkg::ST_IDLE;
			endcase
		end
	end

	len_abort_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_IDLE && start && len_bad) |=> abort_o
		&& st_q == eemu_pkg::ST_IDLE)
		else $error("length mismatch not abandoned");
	mark_value_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_MARK) |=> fl_wr_o &&
		fl_wdata_o == 8'($past(room_left)))
		else $error("marker byte wrong");
	erase_first_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fl_erase_o |-> fl_addr_o == base_q)
		else $error("erase not at page base");
	in_page_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fl_wr_o |-> fl_addr_o - base_q < 16'd64)
		else $error("write outside page");
	stride_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_SCAN_WAIT && !mark_blank && next_fits) |=>
		off_q == 6'($past(next_off)))
		else $error("scan stride wrong");
	full_erase_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_SCAN_WAIT && !mark_blank && !next_fits
		&& store_q) |=> st_q == eemu_pkg::ST_ERASE)
		else $error("full page not erased");
	erase_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fl_erase_o |-> ##[1:20] st_q == eemu_pkg::ST_PROG)
		else $error("no program after erase");
	append_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_SCAN_WAIT && mark_blank && store_q) |=>
		st_q == eemu_pkg::ST_PROG && cnt_q == 4'h0)
		else $error("append not started");
	fetch_last_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_q == eemu_pkg::ST_FETCH_WAIT) |-> fl_rd_o && cnt_q < len_q
		&& fl_addr_o - base_q == {10'h0, last_q} + {12'h0, cnt_q})
		else $error("fetch not from last record");
	store_c: cover property (@(posedge clk_i) st_q == eemu_pkg::ST_MARK);
	erase_c: cover property (@(posedge clk_i) fl_erase_o);
	fetch_c: cover property (@(posedge clk_i) rd_valid_o && rd_ready_i);
	abort_c: cover property (@(posedge clk_i) abort_o);
endmodule
`default_nettype wire

//--- flash_model.sv
// flash page array model facing the record store engine
`timescale 1ns/1ps
`default_nettype none
module flash_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic        erase_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [1024];
	logic       rd_q = 1'b0;
	wire  [9:0] idx = addr_i[9:0];
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// data is only valid around a read, otherwise it shows the inverse
	assign rdata_o = (rd_i | rd_q) ? mem[idx] : ~mem[idx];
	always @(posedge clk_i) begin
		rd_q <= rd_i;
		// programming can only clear bits
		if (wr_i) mem[idx] <= mem[idx] & wdata_i;
		if (erase_i) begin
			for (int i = 0; i < 64; i++) mem[{idx[9:6], 6'h0} + i] <= 8'hFF;
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the flash record store engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        st = 1'b0;
	logic        fe = 1'b0;
	logic        pv = 1'b0;
	logic        rr = 1'b1;
	logic [7:0]  rate = 8'h14;
	logic [3:0]  len = 4'h2;
	logic [7:0]  hi = 8'h00;
	logic [7:0]  lo = 8'h00;
	logic [7:0]  pd = 8'h00;
	logic        pr, rv, frd, fwr, fer, busy, done, abrt;
	logic [7:0]  rd, fwd, frdat, erate;
	logic [15:0] fa;
	int          num_errors = 0;
	int          checks = 0;
	int          pg;
	logic [7:0]  got [$];

	eemu_core dut_u (.clk_i(clk), .sys_rst_i(rst),
		.emulated_store_op_i(st), .emulated_fetch_op_i(fe),
		.clock_rate_param_i(rate), .payload_length_i(len),
		.page_addr_high_i(hi), .page_addr_low_i(lo),
		.pay_valid_i(pv), .pay_ready_o(pr), .pay_data_i(pd),
		.rd_valid_o(rv), .rd_ready_i(rr), .rd_data_o(rd),
		.fl_rd_o(frd), .fl_wr_o(fwr), .fl_erase_o(fer), .fl_addr_o(fa),
		.fl_wdata_o(fwd), .fl_rdata_i(frdat), .busy_o(busy),
		.done_o(done), .abort_o(abrt), .erase_rate_o(erate));
	flash_model flash_u (.clk_i(clk), .rd_i(frd), .wr_i(fwr),
		.erase_i(fer), .addr_i(fa), .wdata_i(fwd), .rdata_o(frdat));

	always #50 clk = ~clk;
	// reader stalls every other cycle
	always @(posedge clk) rr <= ~rr;

	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string m);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error at %0t: %s got %h exp %h", $time, m, s, e);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic reset_dut;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_end(output logic ab);
		int k;
		for (k = 0; k < 2000; k++) begin
			@(negedge clk);
			if (rv === 1'b1 && rr === 1'b1) got.push_back(rd);
			if (done === 1'b1 || abrt === 1'b1) break;
		end
		if (k == 2000) chk(8'h00, 8'h01, "no completion");
		ab = (abrt === 1'b1);
		@(posedge clk);
	endtask

	task automatic store(input logic [7:0] s, input int n, output logic ab);
		for (int i = 0; i < n; i++) begin
			pv <= 1'b1;
			pd <= s + 8'(i);
			@(negedge clk);
			while (pr !== 1'b1) @(negedge clk);
			@(posedge clk);
		end
		pv <= 1'b0;
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		wait_end(ab);
	endtask

	task automatic req_fetch(output logic ab);
		got.delete();
		fe <= 1'b1;
		@(posedge clk);
		fe <= 1'b0;
		wait_end(ab);
	endtask

	task automatic fetch(input logic [7:0] s);
		logic ab;
		req_fetch(ab);
		chk(8'(got.size()), {4'h0, len}, "fetch count");
		foreach (got[i]) chk(got[i], s + 8'(i), "fetch data");
	endtask

	task automatic rec(input int off, input logic [7:0] s);
		for (int i = 0; i < len; i++)
			chk(flash_u.mem[pg + off + i], s + 8'(i), "payload");
		chk(flash_u.mem[pg + off + len], 8'(63 - off - len), "marker");
	endtask

	task automatic test_basic;
		logic ab;
		len <= 4'h2;
		hi <= 8'h01;
		lo <= 8'h40;
		pg = 'h140;
		store(8'hA0, 2, ab);
		chk(ab, 1'b0, "store aborted");
		chk({7'h0, busy}, 8'h00, "busy after done");
		rec(0, 8'hA0);
		chk(erate, 8'h14, "rate");
		fetch(8'hA0);
		$display("test basic done");
	endtask

	task automatic test_fill;
		logic ab;
		reset_dut;
		len <= 4'h3;
		lo <= 8'h80;
		pg = 'h180;
		for (int j = 0; j < 17; j++) begin
			store(8'(j * 5), 3, ab);
			rec((j % 16) * 4, 8'(j * 5));
		end
		chk(flash_u.mem[pg + 4], 8'hFF, "not erased");
		fetch(8'd80);
		$display("test fill done");
	endtask

	task automatic test_abort;
		logic ab;
		len <= 4'h4;
		store(8'h00, 0, ab);
		chk(ab, 1'b1, "store abort");
		chk(flash_u.mem[pg + 4], 8'hFF, "flash touched");
		req_fetch(ab);
		chk(ab, 1'b1, "fetch abort");
		chk(8'(got.size()), 8'h00, "fetch bytes");
		$display("test abort done");
	endtask

	task automatic test_max;
		logic ab;
		reset_dut;
		len <= 4'hF;
		hi <= 8'h02;
		lo <= 8'hC0;
		pg = 'h2C0;
		for (int j = 0; j < 5; j++) begin
			store(8'(j * 20), 15, ab);
			rec((j % 4) * 16, 8'(j * 20));
		end
		fetch(8'd80);
		$display("test max done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		test_basic;
		test_fill;
		test_abort;
		test_max;
		conclude;
	end

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		conclude;
	end
endmodule
`default_nettype wire
